/* File: design/pmc_regs.vh */
// Register map, field positions, reset values and timing counts of the clock controller.
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define PMC_IDX_EXT_IRQ_FLAGS      8'h91
`define PMC_IDX_PMR       8'hc4
`define PMC_IDX_STATUS    8'hc5
`define PMC_ADDR_EXT_IRQ_FLAGS     12'h244
`define PMC_ADDR_PMR      12'h310
`define PMC_ADDR_STATUS   12'h314

// ****************************************
// Field positions
// ****************************************
`define PMC_SRC_SEL_BIT   3
`define PMC_IN_USE_BIT    2
`define PMC_DIV_HI_BIT    7
`define PMC_DIV_LO_BIT    6
`define PMC_AUTO_RET_BIT  5
`define PMC_AMP_OFF_BIT   3
`define PMC_XT_READY_BIT  4

// ****************************************
// Divider codes and reset values
// ****************************************
`define PMC_DIV_RSVD      2'h0
`define PMC_DIV_4         2'h1
`define PMC_DIV_64        2'h2
`define PMC_DIV_1024      2'h3
`define PMC_RST_DIV       2'h1
`define PMC_RST_SRC_SEL   1'h1
`define PMC_RST_XT_READY  1'h1

// ****************************************
// Timing counts
// ****************************************
`define PMC_XT_WARM_CLKS  65536
`define PMC_LAST_4        10'h003
`define PMC_LAST_64       10'h03f
`define PMC_LAST_1024     10'h3ff

`endif

/* File: design/pmc_clock_ctrl.v */
// Machine-cycle rate divider and clock source control for the reduced-power run mode.
//
// Chosen here: the APB slave port.
`include "pmc_regs.vh"

module pmc_clock_ctrl #(
	parameter XT_WARM_CLKS = `PMC_XT_WARM_CLKS,
	parameter NUM_EXT_IRQ  = 6
) (
	// APB slave
	input  wire                   pclk,
	input  wire                   presetn,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [11:0]            paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output reg                    pready,
	output reg                    pslverr,
	// Oscillator pins
	input  wire                   xtal_clk_in,
	input  wire                   ring_clk_in,
	// Interrupt logic
	input  wire [NUM_EXT_IRQ-1:0] ext_irq_req,
	input  wire [NUM_EXT_IRQ-1:0] ext_irq_en,
	input  wire [NUM_EXT_IRQ-1:0] ext_irq_high,
	input  wire                   powerfail_level_active,
	input  wire                   high_level_active,
	input  wire                   low_level_active,
	// Serial ports
	input  wire                   port0_rx_enable,
	input  wire                   port1_rx_enable,
	input  wire                   port0_start_edge,
	input  wire                   port1_start_edge,
	input  wire                   port0_tx_buffer_write,
	input  wire                   port1_tx_buffer_write,
	input  wire                   port0_rx_busy,
	input  wire                   port0_tx_busy,
	input  wire                   port1_rx_busy,
	input  wire                   port1_tx_busy,
	// Clock outputs
	output reg                    source_tick,
	output reg                    machine_cycle_en,
	output reg                    crystal_amp_disable,
	output reg                    oscillator_in_use,
	output reg  [1:0]             active_rate
);

	// ****************************************
	// Helpers
	// ****************************************
	// Last count of the divider for a rate code.
	function [9:0] div_last;
		input [1:0] rate;
		begin
			case (rate)
				`PMC_DIV_64:   div_last = `PMC_LAST_64;
				`PMC_DIV_1024: div_last = `PMC_LAST_1024;
				default:       div_last = `PMC_LAST_4;
			endcase
		end
	endfunction

	// Rising edge on a synchronised oscillator pin.
	function rise;
		input [1:0] hist;
		begin
			rise = hist[0] & ~hist[1];
		end
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg  [1:0]  xt_sync;
	reg  [1:0]  rg_sync;
	reg  [1:0]  xt_hist;
	reg  [1:0]  rg_hist;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xt_sync <= 2'h0;
			rg_sync <= 2'h0;
			xt_hist <= 2'h0;
			rg_hist <= 2'h0;
		end else begin
			xt_sync <= {xt_sync[0], xtal_clk_in};
			rg_sync <= {rg_sync[0], ring_clk_in};
			xt_hist <= {xt_hist[0], xt_sync[1]};
			rg_hist <= {rg_hist[0], rg_sync[1]};
		end
	end

	wire        xt_tick;
	wire        rg_tick;
	assign xt_tick = rise(xt_hist) & ~crystal_amp_disable;
	assign rg_tick = rise(rg_hist);

	// ****************************************
	// Register state
	// ****************************************
	reg  [1:0]  div_sel;
	reg         auto_return_enable;
	reg         clock_source_select;
	reg         crystal_ready;
	reg  [31:0] warm_cnt;
	reg  [9:0]  div_cnt;
	reg  [1:0]  rate_pend;
	reg         src_pend;

	wire        wr_en;
	wire        rd_en;
	wire        hit_ext_irq_flags;
	wire        hit_pmr;
	wire        hit_stat;
	assign hit_ext_irq_flags = (paddr == `PMC_ADDR_EXT_IRQ_FLAGS);
	assign hit_pmr  = (paddr == `PMC_ADDR_PMR);
	assign hit_stat = (paddr == `PMC_ADDR_STATUS);
	assign wr_en    = psel & penable & pready & pwrite;
	assign rd_en    = psel & penable & ~pready & ~pwrite;

	wire [1:0]  wr_div;
	assign wr_div = pwdata[`PMC_DIV_HI_BIT:`PMC_DIV_LO_BIT];

	// ****************************************
	// Switchback triggers
	// ****************************************
	reg         irq_can_take;
	integer     i;

	always @* begin
		irq_can_take = 1'b0;
		for (i = 0; i < NUM_EXT_IRQ; i = i + 1) begin
			if (ext_irq_req[i] && ext_irq_en[i] && !powerfail_level_active) begin
				if (ext_irq_high[i] ? !high_level_active : !(high_level_active || low_level_active)) begin
					irq_can_take = 1'b1;
				end
			end
		end
	end

	wire        rx_wake;
	wire        tx_wake;
	wire        switchback;
	assign rx_wake    = (port0_start_edge & port0_rx_enable) | (port1_start_edge & port1_rx_enable);
	assign tx_wake    = port0_tx_buffer_write | port1_tx_buffer_write;
	assign switchback = auto_return_enable & (irq_can_take | rx_wake | tx_wake);

	// ****************************************
	// Control register writes
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_sel             <= `PMC_RST_DIV;
			auto_return_enable  <= 1'b0;
			crystal_amp_disable <= 1'b0;
			clock_source_select <= `PMC_RST_SRC_SEL;
		end else begin
			if (switchback) begin
				// Only the divider returns; the source stays as software left it.
				div_sel <= `PMC_DIV_4;
			end else if (wr_en && hit_pmr) begin
				if (wr_div == `PMC_DIV_4) begin
					div_sel <= wr_div;
				end else if (wr_div != `PMC_DIV_RSVD && div_sel == `PMC_DIV_4 && rate_pend == `PMC_DIV_4) begin
					// The pending stage must hold the four-clock rate too, so the applied rate never moves slow to slow.
					div_sel <= wr_div;
				end
			end
			if (wr_en && hit_pmr) begin
				auto_return_enable <= pwdata[`PMC_AUTO_RET_BIT];
				if (!pwdata[`PMC_AMP_OFF_BIT] || !clock_source_select) begin
					crystal_amp_disable <= pwdata[`PMC_AMP_OFF_BIT];
				end
			end
			if (wr_en && hit_ext_irq_flags) begin
				if (!pwdata[`PMC_SRC_SEL_BIT]) begin
					clock_source_select <= 1'b0;
				end else if (crystal_ready && !crystal_amp_disable) begin
					clock_source_select <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Crystal warm-up
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crystal_ready <= `PMC_RST_XT_READY;
			warm_cnt      <= 32'h0;
		end else if (crystal_amp_disable) begin
			crystal_ready <= 1'b0;
			warm_cnt      <= 32'h0;
		end else if (!crystal_ready && xt_tick) begin
			if (warm_cnt == XT_WARM_CLKS - 1) begin
				crystal_ready <= 1'b1;
				warm_cnt      <= 32'h0;
			end else begin
				warm_cnt <= warm_cnt + 32'h1;
			end
		end
	end

	// ****************************************
	// Machine-cycle divider
	// ****************************************
	wire        sel_tick;
	wire        cyc_end;
	assign sel_tick = oscillator_in_use ? rg_tick : xt_tick;
	assign cyc_end  = sel_tick & (div_cnt == div_last(active_rate));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt           <= 10'h0;
			rate_pend         <= `PMC_RST_DIV;
			src_pend          <= `PMC_RST_SRC_SEL;
			active_rate       <= `PMC_RST_DIV;
			oscillator_in_use <= 1'b0;
			source_tick       <= 1'b0;
			machine_cycle_en  <= 1'b0;
		end else begin
			source_tick      <= sel_tick;
			machine_cycle_en <= cyc_end;
			if (sel_tick) begin
				div_cnt <= cyc_end ? 10'h0 : div_cnt + 10'h1;
			end
			if (cyc_end) begin
				// A choice seen at one boundary is applied at the next.
				rate_pend   <= div_sel;
				active_rate <= rate_pend;
				src_pend    <= clock_source_select;
				if (!src_pend || crystal_ready) begin
					oscillator_in_use <= ~src_pend;
				end
			end
		end
	end

	// ****************************************
	// APB read and response
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~(hit_ext_irq_flags | hit_pmr | hit_stat);
			if (rd_en) begin
				prdata <= 32'h0;
				if (hit_ext_irq_flags) begin
					prdata[`PMC_SRC_SEL_BIT] <= clock_source_select;
					prdata[`PMC_IN_USE_BIT]  <= oscillator_in_use;
				end
				if (hit_pmr) begin
					prdata[`PMC_DIV_HI_BIT:`PMC_DIV_LO_BIT] <= div_sel;
					prdata[`PMC_AUTO_RET_BIT] <= auto_return_enable;
					prdata[`PMC_AMP_OFF_BIT]  <= crystal_amp_disable;
				end
				if (hit_stat) begin
					prdata[7:0] <= {powerfail_level_active, high_level_active, low_level_active,
						crystal_ready, port1_tx_busy, port1_rx_busy, port0_tx_busy, port0_rx_busy};
				end
			end
		end
	end

endmodule

/* File: tb/pmc_asserts.sv */
// Concurrent checks on the ports of the clock controller.
module pmc_asserts (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// APB
	input wire logic       pwrite,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	// Clock outputs
	input wire logic       source_tick,
	input wire logic       machine_cycle_en,
	input wire logic       crystal_amp_disable,
	input wire logic       oscillator_in_use,
	input wire logic [1:0] active_rate
);
	logic [10:0] ticks;
	logic        skip;
	logic [1:0]  rate_q;
	logic        src_q;
	wire         moved = (active_rate != rate_q) || (oscillator_in_use != src_q);
	wire  [10:0] want  = active_rate[1] ? (active_rate[0] ? 11'h400 : 11'h040) : 11'h004;
	// Counts ticks per machine cycle; a rate or source move voids the count in progress.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ticks <= 11'h000;
			skip <= 1'b1;
			rate_q <= 2'h1;
			src_q <= 1'b0;
		end else begin
			ticks <= machine_cycle_en ? 11'h000 : ticks + 11'(source_tick);
			skip <= moved || (skip && !machine_cycle_en);
			rate_q <= active_rate;
			src_q <= oscillator_in_use;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_cycle_end;
		machine_cycle_en || $past(machine_cycle_en) || $past(machine_cycle_en, 2);
	endsequence
	property p_ready;
		s_access |=> pready;
	endproperty
	property p_err;
		pslverr |-> pready;
	endproperty
	property p_rate_code;
		active_rate != 2'h0;
	endproperty
	property p_slow_entry;
		$changed(active_rate) && active_rate[1] |-> $past(active_rate) == 2'h1;
	endproperty
	property p_rate_at_end;
		$changed(active_rate) |-> s_cycle_end;
	endproperty
	property p_src_at_end;
		$changed(oscillator_in_use) |-> s_cycle_end;
	endproperty
	property p_tick_count;
		machine_cycle_en && !skip && !moved |-> ticks + 11'(source_tick) == want;
	endproperty
	property p_amp_write;
		$rose(crystal_amp_disable) |-> $past(pwrite && pready) || $past(pwrite && pready, 2);
	endproperty
	property p_mc_pulse;
		machine_cycle_en |=> !machine_cycle_en;
	endproperty
	a_ready: assert property (p_ready) else $error("pready missing after access");
	a_err: assert property (p_err) else $error("pslverr without pready");
	a_rate_code: assert property (p_rate_code) else $error("reserved rate applied");
	a_slow_entry: assert property (p_slow_entry) else $error("slow rate entered from slow rate");
	a_rate_at_end: assert property (p_rate_at_end) else $error("rate moved mid cycle");
	a_src_at_end: assert property (p_src_at_end) else $error("source moved mid cycle");
	a_tick_count: assert property (p_tick_count) else $error("wrong ticks per cycle");
	a_amp_write: assert property (p_amp_write) else $error("amplifier off without write");
	a_mc_pulse: assert property (p_mc_pulse) else $error("cycle enable too long");
endmodule
bind pmc_clock_ctrl pmc_asserts pmc_asserts_inst (.pclk, .presetn, .pwrite, .psel, .penable, .pready, .pslverr,
	.source_tick, .machine_cycle_en, .crystal_amp_disable, .oscillator_in_use, .active_rate);

/* File: tb/pmc_osc_model.sv */
// Crystal and ring oscillator pins seen by the clock controller.
module pmc_osc_model #(
	parameter int XT_HALF = 40,
	parameter int RG_HALF = 150
) (
	// Amplifier control
	input  wire logic crystal_amp_disable,
	// Oscillator pins
	output logic      xtal_clk_in,
	output logic      ring_clk_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		xtal_clk_in = 1'b0;
		ring_clk_in = 1'b0;
	end
	// The crystal stands still at low level while its amplifier is off.
	always #(XT_HALF) xtal_clk_in = crystal_amp_disable ? 1'b0 : !xtal_clk_in;
	always #(RG_HALF) ring_clk_in = !ring_clk_in;
endmodule

/* File: tb/pmc_clock_ctrl_test.sv */
// Self-checking bench of the clock controller.
`include "pmc_regs.vh"
module pmc_clock_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, xtal_clk_in, ring_clk_in;
	logic [5:0]  ext_irq_req = 6'h00, ext_irq_en = 6'h01;
	logic [8:0]  lv = 9'h000;
	logic [3:0]  pu = 4'h0;
	logic        source_tick, machine_cycle_en, crystal_amp_disable, oscillator_in_use;
	logic [1:0]  active_rate;
	int          failures = 0, n_compared = 0, cyc = 0;
	pmc_clock_ctrl #(.XT_WARM_CLKS(8)) pmc_clock_ctrl_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.xtal_clk_in, .ring_clk_in, .ext_irq_req, .ext_irq_en, .ext_irq_high(6'h00),
		.powerfail_level_active(lv[0]), .high_level_active(lv[1]), .low_level_active(lv[2]),
		.port0_rx_enable(lv[3]), .port1_rx_enable(lv[4]), .port0_rx_busy(lv[5]), .port0_tx_busy(lv[6]),
		.port1_rx_busy(lv[7]), .port1_tx_busy(lv[8]), .port0_start_edge(pu[0]), .port1_start_edge(pu[1]),
		.port0_tx_buffer_write(pu[2]), .port1_tx_buffer_write(pu[3]), .source_tick, .machine_cycle_en,
		.crystal_amp_disable, .oscillator_in_use, .active_rate);
	pmc_osc_model pmc_osc_model_inst (.crystal_amp_disable, .xtal_clk_in, .ring_clk_in);
	always #5 pclk = !pclk;
	// ****
	// Tasks
	// ****
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge pclk) begin
		if (++cyc == 90000) begin
			failures++;
			close_out;
		end
	end
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rchk(string what, logic [11:0] a, logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	task automatic settle;
		int n = 0;
		int e = 0;
		while (e < 2 && n < 20000) begin
			@(posedge pclk);
			n++;
			if (machine_cycle_en === 1'b1)
				e++;
		end
	endtask
	task automatic trig(int k);
		@(posedge pclk);
		if (k == 0)
			ext_irq_req[0] <= 1'b1;
		else
			pu[k-1] <= 1'b1;
		@(posedge pclk);
		ext_irq_req[0] <= 1'b0;
		pu <= 4'h0;
	endtask
	// ****
	// Tests
	// ****
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rchk("pmr", `PMC_ADDR_PMR, 32'h40);
		rchk("ext_irq_flags", `PMC_ADDR_EXT_IRQ_FLAGS, 32'h08);
		rchk("status", `PMC_ADDR_STATUS, 32'h10);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped", {rd[30:0], er}, 32'h1);
		lv <= 9'h13d;
		wr(`PMC_ADDR_STATUS, 32'h00);
		rchk("status bits", `PMC_ADDR_STATUS, 32'hb9);
		lv <= 9'h018;
		wr(`PMC_ADDR_PMR, 32'h48);
		rchk("amp refused", `PMC_ADDR_PMR, 32'h40);
		$display("test reset ended");
		wr(`PMC_ADDR_PMR, 32'h80);
		chk("rate held", active_rate, 2'h1);
		repeat (3000) @(posedge pclk);
		chk("rate 64", active_rate, 2'h2);
		wr(`PMC_ADDR_PMR, 32'hc0);
		wr(`PMC_ADDR_PMR, 32'h00);
		rchk("pmr 64", `PMC_ADDR_PMR, 32'h80);
		wr(`PMC_ADDR_PMR, 32'h40);
		for (int i = 0; i < 3000 && active_rate !== 2'h1; i++)
			@(posedge pclk);
		settle;
		wr(`PMC_ADDR_PMR, 32'hc0);
		repeat (30000) @(posedge pclk);
		chk("rate 1024", active_rate, 2'h3);
		wr(`PMC_ADDR_PMR, 32'h40);
		$display("test divider ended");
		wr(`PMC_ADDR_EXT_IRQ_FLAGS, 32'h00);
		for (int i = 0; i < 40000 && oscillator_in_use !== 1'b1; i++)
			@(posedge pclk);
		rchk("ext_irq_flags ring", `PMC_ADDR_EXT_IRQ_FLAGS, 32'h04);
		for (int k = 0; k < 5; k++) begin
			wr(`PMC_ADDR_PMR, 32'ha0);
			trig(k);
			rchk("switchback", `PMC_ADDR_PMR, 32'h60);
			chk("source kept", oscillator_in_use, 1'b1);
			settle;
		end
		wr(`PMC_ADDR_PMR, 32'ha0);
		lv <= 9'h002;
		trig(0);
		trig(1);
		rchk("blocked", `PMC_ADDR_PMR, 32'ha0);
		wr(`PMC_ADDR_PMR, 32'h40);
		settle;
		wr(`PMC_ADDR_PMR, 32'h80);
		trig(3);
		rchk("no return", `PMC_ADDR_PMR, 32'h80);
		wr(`PMC_ADDR_PMR, 32'h40);
		lv <= 9'h000;
		$display("test switchback ended");
		wr(`PMC_ADDR_PMR, 32'h48);
		@(posedge pclk);
		chk("amp pin", crystal_amp_disable, 1'b1);
		rchk("ready low", `PMC_ADDR_STATUS, 32'h00);
		wr(`PMC_ADDR_EXT_IRQ_FLAGS, 32'h08);
		rchk("xtal refused", `PMC_ADDR_EXT_IRQ_FLAGS, 32'h04);
		wr(`PMC_ADDR_PMR, 32'h40);
		rchk("warming", `PMC_ADDR_STATUS, 32'h00);
		for (int i = 0; i < 200 && rd[4] !== 1'b1; i++)
			apb(1'b0, `PMC_ADDR_STATUS, 32'h0);
		chk("ready", rd, 32'h10);
		wr(`PMC_ADDR_EXT_IRQ_FLAGS, 32'h08);
		for (int i = 0; i < 2000 && oscillator_in_use !== 1'b0; i++)
			@(posedge pclk);
		rchk("ext_irq_flags xtal", `PMC_ADDR_EXT_IRQ_FLAGS, 32'h08);
		$display("test source ended");
		close_out;
	end
endmodule
